// >>> lar_defines.svh
`ifndef LAR_DEFINES_SVH
`define LAR_DEFINES_SVH
// register indices; byte address is four times the index
`define LAR_IDX_LUT_DATA  5'h17
`define LAR_IDX_PIN_DIR   5'h18
`define LAR_IDX_PIN_STATE 5'h19
`define LAR_IDX_SCRATCH   5'h1A
`define LAR_IDX_ROT_MODE  5'h1B
`define LAR_IDX_STRIDE    5'h1C
`define LAR_IDX_TEST_A    5'h1E
`define LAR_IDX_TEST_B    5'h1F
// field positions
`define LAR_LUT_NIB_HI    7
`define LAR_LUT_NIB_LO    4
`define LAR_ROT_EN_BIT    7
`define LAR_ROT_ALT_BIT   6
`define LAR_ROT_SEL_HI    1
`define LAR_PIN_HI        4
// reset values and fixed figures
`define LAR_RST_BYTE      8'h00
`define LAR_RST_PINS      5'h00
`define LAR_RST_NIB       4'h0
`define LAR_STRIDE_ZERO   9'h100
`endif

// >>> lar_pkg.sv
`default_nettype none
package lar_pkg;
  typedef enum logic [1:0] {
    LAR_COMP_RED,
    LAR_COMP_GREEN,
    LAR_COMP_BLUE
  } lar_comp_t;
  typedef enum logic {
    LAR_ST_IDLE,
    LAR_ST_RESP
  } lar_apb_st_t;
endpackage : lar_pkg
`default_nettype wire

// >>> lar_top.sv
// Operation
// [RULE1] colour table entry is committed only when its blue part is written
// [RULE2] colour data sits in bits 7-4; bits 3-0 are unused
// [RULE3] each data access hits the pointed entry, then advances the pointer
// [RULE4] direction bit 0 makes the pin an input, readable in its state bit
// [RULE5] direction bit 1 drives the pin from the written state bit
// [RULE6] direction bits do nothing while pins carry upper panel data bits
// [RULE7] scratch register holds eight free bits affecting nothing else
// [RULE8] rotation enable bit 7 selects rotated or landscape display
// [RULE9] bit 6 picks default or alternate rotation, ignored when disabled
// [RULE10] software writes 0 to reserved rotation bit 2
// [RULE11] in landscape pixel clock is base, memory clock follows config bit
// [RULE12] default rotation: select 0..3 divides both clocks by 1,2,4,8
// [RULE13] alternate rotation: pixel 2,2,4,8 and memory 1,1,2,4 divisors
// [RULE14] base clock is input clock, or half of it when bit 4 set
// [RULE15] stride value zero means 256 bytes
// [RULE16] stride value n from 1 to FFh means n bytes
// [RULE17] software never writes the factory test registers
// [RULE18] unused bits read 0 and ignore writes
// [RULE19] output pin state bit reads back the last written value
//
// Local design decision: the APB slave port.
`default_nettype none
`include "lar_defines.svh"

module lar_top
  import lar_pkg::*;
(
  input  wire logic        CLK_IN,
  input  wire logic        ARST_N_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        LUT_PTR_LOAD_IN,
  input  wire logic [7:0]  LUT_PTR_IN,
  input  wire logic [4:0]  GPIO_IN,
  output logic      [4:0]  GPIO_OUT,
  output logic      [4:0]  GPIO_OE_OUT,
  input  wire logic        PANEL_DATA_MODE_IN,
  input  wire logic        CLK_DIV2_SEL_IN,
  input  wire logic        MCLK_CFG_IN,
  output logic             ROT_ENABLE_OUT,
  output logic             ROT_ALT_OUT,
  output logic             PCLK_EN_OUT,
  output logic             MCLK_EN_OUT,
  output logic      [8:0]  STRIDE_BYTES_OUT
);

  function automatic logic hit(input logic [7:0] a,
                               input logic [4:0] idx);
    return a == {1'b0, idx, 2'b00};
  endfunction : hit

  function automatic logic [2:0] div_mask(input logic [1:0] c);
    return 3'((4'h1 << c) - 4'h1);
  endfunction : div_mask

  // divisor exponents for pixel and memory clocks
  function automatic logic [1:0] pclk_code(input logic en,
                                           input logic alt,
                                           input logic [1:0] sel);
    if (!en) begin
      return 2'h0;
    end
    if (!alt) begin
      return sel;
    end
    return (sel == 2'h0) ? 2'h1 : sel;
  endfunction : pclk_code

  function automatic logic [1:0] mclk_code(input logic en,
                                           input logic alt,
                                           input logic [1:0] sel,
                                           input logic lcfg);
    if (!en) begin
      return lcfg ? 2'h1 : 2'h0;
    end
    if (!alt) begin
      return sel;
    end
    return (sel == 2'h0) ? 2'h0 : 2'(sel - 2'h1);
  endfunction : mclk_code

  lar_apb_st_t st_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_d;
  logic        acc;
  logic        done;
  logic        wr_done;
  logic        rd_done;
  logic        hit_lut;
  logic        hit_dir;
  logic        hit_st;
  logic        hit_scr;
  logic        hit_rot;
  logic        hit_str;
  logic        hit_test;
  logic        map_ok;
  logic [3:0]  wr_nib;

  logic [3:0]  lut_r_q [256];
  logic [3:0]  lut_g_q [256];
  logic [3:0]  lut_b_q [256];
  logic [7:0]  ent_q;
  lar_comp_t   comp_q;
  logic [3:0]  stage_r_q;
  logic [3:0]  stage_g_q;
  logic [3:0]  lut_nib;
  logic        lut_acc;

  logic [4:0]  dir_q;
  logic [4:0]  state_q;
  logic [4:0]  gpio_s_q;
  logic [4:0]  dir_eff;
  logic [4:0]  pin_rd;
  logic [4:0]  oe_q;
  logic [4:0]  out_q;
  logic [7:0]  scratch_q;

  logic        rot_en_q;
  logic        rot_alt_q;
  logic [1:0]  rot_sel_q;
  logic        rot_en_o_q;
  logic        rot_alt_o_q;
  logic [7:0]  stride_q;
  logic [8:0]  stride_o_q;

  logic        half_q;
  logic        base_tick;
  logic [2:0]  cnt_q;
  logic [1:0]  pcode;
  logic [1:0]  mcode;
  logic        pclk_q;
  logic        mclk_q;

  // bus decode
  assign acc      = PSEL_IN & PENABLE_IN;
  assign done     = (st_q == LAR_ST_RESP) & acc;
  assign wr_done  = done & PWRITE_IN;
  assign rd_done  = done & ~PWRITE_IN;
  assign hit_lut  = hit(PADDR_IN, `LAR_IDX_LUT_DATA);
  assign hit_dir  = hit(PADDR_IN, `LAR_IDX_PIN_DIR);
  assign hit_st   = hit(PADDR_IN, `LAR_IDX_PIN_STATE);
  assign hit_scr  = hit(PADDR_IN, `LAR_IDX_SCRATCH);
  assign hit_rot  = hit(PADDR_IN, `LAR_IDX_ROT_MODE);
  assign hit_str  = hit(PADDR_IN, `LAR_IDX_STRIDE);
  assign hit_test = hit(PADDR_IN, `LAR_IDX_TEST_A) |
                    hit(PADDR_IN, `LAR_IDX_TEST_B);
  assign map_ok   = hit_lut | hit_dir | hit_st | hit_scr |
                    hit_rot | hit_str | hit_test;
  assign wr_nib   = PWDATA_IN[`LAR_LUT_NIB_HI:`LAR_LUT_NIB_LO];

  // one wait state: answer in the cycle after the access phase starts
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      st_q      <= LAR_ST_IDLE;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      unique case (st_q)
        LAR_ST_IDLE: begin
          if (acc) begin
            st_q      <= LAR_ST_RESP;
            pready_q  <= 1'b1;
            prdata_q  <= PWRITE_IN ? 32'h0 : rd_d;
            // test registers refuse writes with an error answer
            pslverr_q <= ~map_ok | (PWRITE_IN & hit_test); // RULE17
          end
        end
        LAR_ST_RESP: begin
          st_q      <= LAR_ST_IDLE;
          pready_q  <= 1'b0;
          pslverr_q <= 1'b0;
          prdata_q  <= 32'h0;
        end
      endcase
    end
  end

  assign lut_acc = done & hit_lut;

  always_comb begin
    unique case (comp_q)
      LAR_COMP_RED:   lut_nib = lut_r_q[ent_q];
      LAR_COMP_GREEN: lut_nib = lut_g_q[ent_q];
      LAR_COMP_BLUE:  lut_nib = lut_b_q[ent_q];
      default:        lut_nib = `LAR_RST_NIB;
    endcase
  end

  assign dir_eff = dir_q & ~{5{PANEL_DATA_MODE_IN}}; // RULE6
  assign pin_rd  = (dir_eff & state_q) | (~dir_eff & gpio_s_q); // RULE4 RULE19

  // read mux; unused bits stay zero
  always_comb begin
    rd_d = 32'h0; // RULE18
    if (hit_lut) begin
      rd_d[`LAR_LUT_NIB_HI:`LAR_LUT_NIB_LO] = lut_nib; // RULE2
    end
    if (hit_dir) begin
      rd_d[`LAR_PIN_HI:0] = dir_q;
    end
    if (hit_st) begin
      rd_d[`LAR_PIN_HI:0] = pin_rd;
    end
    if (hit_scr) begin
      rd_d[7:0] = scratch_q; // RULE7
    end
    if (hit_rot) begin
      rd_d[`LAR_ROT_EN_BIT]    = rot_en_q;
      rd_d[`LAR_ROT_ALT_BIT]   = rot_alt_q;
      rd_d[`LAR_ROT_SEL_HI:0]  = rot_sel_q;
    end
    if (hit_str) begin
      rd_d[7:0] = stride_q;
    end
  end

  // table pointer; an external load wins over an access advance
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ent_q  <= `LAR_RST_BYTE;
      comp_q <= LAR_COMP_RED;
    end else if (LUT_PTR_LOAD_IN) begin
      ent_q  <= LUT_PTR_IN;
      comp_q <= LAR_COMP_RED;
    end else if (lut_acc) begin
      unique case (comp_q)
        LAR_COMP_RED:   comp_q <= LAR_COMP_GREEN; // RULE3
        LAR_COMP_GREEN: comp_q <= LAR_COMP_BLUE; // RULE3
        default: begin
          comp_q <= LAR_COMP_RED; // RULE3
          ent_q  <= ent_q + 8'h01; // RULE3
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      stage_r_q <= `LAR_RST_NIB;
      stage_g_q <= `LAR_RST_NIB;
    end else if (lut_acc && PWRITE_IN) begin
      if (comp_q == LAR_COMP_RED) begin
        stage_r_q <= wr_nib; // RULE1
      end
      if (comp_q == LAR_COMP_GREEN) begin
        stage_g_q <= wr_nib; // RULE1
      end
    end
  end

  // table storage, no reset
  always_ff @(posedge CLK_IN) begin
    if (lut_acc && PWRITE_IN && comp_q == LAR_COMP_BLUE) begin
      lut_r_q[ent_q] <= stage_r_q; // RULE1
      lut_g_q[ent_q] <= stage_g_q; // RULE1
      lut_b_q[ent_q] <= wr_nib; // RULE1 RULE2
    end
  end

  // general-purpose pins
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      dir_q     <= `LAR_RST_PINS;
      state_q   <= `LAR_RST_PINS;
      gpio_s_q  <= `LAR_RST_PINS;
      oe_q      <= `LAR_RST_PINS;
      out_q     <= `LAR_RST_PINS;
      scratch_q <= `LAR_RST_BYTE;
    end else begin
      gpio_s_q <= GPIO_IN; // RULE4
      oe_q     <= dir_eff; // RULE5 RULE6
      out_q    <= state_q & dir_eff; // RULE5
      if (wr_done && hit_dir) begin
        dir_q <= PWDATA_IN[`LAR_PIN_HI:0];
      end
      if (wr_done && hit_st) begin
        state_q <= PWDATA_IN[`LAR_PIN_HI:0]; // RULE5 RULE19
      end
      if (wr_done && hit_scr) begin
        scratch_q <= PWDATA_IN[7:0]; // RULE7
      end
    end
  end

  // rotation mode and stride
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rot_en_q    <= 1'b0;
      rot_alt_q   <= 1'b0;
      rot_sel_q   <= 2'h0;
      rot_en_o_q  <= 1'b0;
      rot_alt_o_q <= 1'b0;
      stride_q    <= `LAR_RST_BYTE;
      stride_o_q  <= `LAR_STRIDE_ZERO;
    end else begin
      rot_en_o_q  <= rot_en_q; // RULE8
      rot_alt_o_q <= rot_en_q & rot_alt_q; // RULE9
      stride_o_q  <= (stride_q == 8'h00) ? `LAR_STRIDE_ZERO // RULE15
                                         : {1'b0, stride_q}; // RULE16
      if (wr_done && hit_rot) begin
        // reserved and unused bits are dropped
        rot_en_q  <= PWDATA_IN[`LAR_ROT_EN_BIT]; // RULE8
        rot_alt_q <= PWDATA_IN[`LAR_ROT_ALT_BIT]; // RULE9
        rot_sel_q <= PWDATA_IN[`LAR_ROT_SEL_HI:0]; // RULE10
      end
      if (wr_done && hit_str) begin
        stride_q <= PWDATA_IN[7:0];
      end
    end
  end

  // clock strobes derived from the base clock
  assign base_tick = ~CLK_DIV2_SEL_IN | half_q; // RULE14
  assign pcode = pclk_code(rot_en_q, rot_alt_q, rot_sel_q); // RULE11 RULE12
  assign mcode = mclk_code(rot_en_q, rot_alt_q, rot_sel_q,
                           MCLK_CFG_IN); // RULE12 RULE13

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      half_q <= 1'b0;
      cnt_q  <= 3'h0;
      pclk_q <= 1'b0;
      mclk_q <= 1'b0;
    end else begin
      half_q <= ~half_q;
      if (base_tick) begin
        cnt_q <= cnt_q + 3'h1;
      end
      pclk_q <= base_tick && ((cnt_q & div_mask(pcode)) == 3'h0); // RULE13
      mclk_q <= base_tick && ((cnt_q & div_mask(mcode)) == 3'h0); // RULE13
    end
  end

  assign PRDATA_OUT       = prdata_q;
  assign PREADY_OUT       = pready_q;
  assign PSLVERR_OUT      = pslverr_q;
  assign GPIO_OUT         = out_q;
  assign GPIO_OE_OUT      = oe_q;
  assign ROT_ENABLE_OUT   = rot_en_o_q;
  assign ROT_ALT_OUT      = rot_alt_o_q;
  assign PCLK_EN_OUT      = pclk_q;
  assign MCLK_EN_OUT      = mclk_q;
  assign STRIDE_BYTES_OUT = stride_o_q;

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!ARST_N_IN);

  logic [7:0] ent_prev;
  assign ent_prev = ent_q;

  chk_lut_blue_commit: assert property ( // RULE1
    (lut_acc && PWRITE_IN && comp_q == LAR_COMP_BLUE && !LUT_PTR_LOAD_IN)
    |=> lut_b_q[$past(ent_prev)] == $past(wr_nib)
        && lut_r_q[$past(ent_prev)] == $past(stage_r_q))
    else $error("blue write did not commit entry");

  chk_lut_ptr_adv: assert property ( // RULE3
    (lut_acc && comp_q == LAR_COMP_BLUE && !LUT_PTR_LOAD_IN)
    |=> comp_q == LAR_COMP_RED && ent_q == $past(ent_prev) + 8'h01)
    else $error("table pointer did not advance");

  chk_unused_zero: assert property ( // RULE18
    PREADY_OUT |-> PRDATA_OUT[31:8] == 24'h0)
    else $error("unused read bits not zero");

  chk_lut_low_nib: assert property ( // RULE2
    (rd_done && hit_lut) |-> PRDATA_OUT[3:0] == 4'h0)
    else $error("colour data low nibble not zero");

  chk_panel_pins: assert property ( // RULE6
    PANEL_DATA_MODE_IN |=> GPIO_OE_OUT == 5'h00)
    else $error("pins driven during panel data mode");

  chk_pin_drive: assert property ( // RULE5
    (dir_q[0] && !PANEL_DATA_MODE_IN) ##1 dir_q[0]
    |-> GPIO_OE_OUT[0] && GPIO_OUT[0] == $past(state_q[0]))
    else $error("output pin not driven from state bit");

  chk_alt_gated: assert property ( // RULE9
    !ROT_ENABLE_OUT |-> !ROT_ALT_OUT)
    else $error("alternate mode shown while rotation off");

  chk_land_pclk: assert property ( // RULE11
    (!rot_en_q && !CLK_DIV2_SEL_IN) |=> PCLK_EN_OUT)
    else $error("landscape pixel clock not base rate");

  chk_alt_mclk: assert property ( // RULE13
    (rot_en_q && rot_alt_q && rot_sel_q == 2'h0 && !CLK_DIV2_SEL_IN)[*2]
    |=> MCLK_EN_OUT && !($past(PCLK_EN_OUT) && PCLK_EN_OUT))
    else $error("alternate mode clock ratio wrong");

  logic [3:0] gap_q;
  logic [3:0] d8_run_q;
  logic       div8_cfg;

  assign div8_cfg = rot_en_q && !rot_alt_q && rot_sel_q == 2'h3
                    && !CLK_DIV2_SEL_IN;

  // checker helpers: cycles since the last pixel strobe, and how long
  // the divide-by-eight setting has held; both saturate
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      gap_q    <= 4'h0;
      d8_run_q <= 4'h0;
    end else begin
      if (pclk_q) begin
        gap_q <= 4'h0;
      end else if (gap_q != 4'hF) begin
        gap_q <= gap_q + 4'h1;
      end
      if (!div8_cfg) begin
        d8_run_q <= 4'h0;
      end else if (d8_run_q != 4'hF) begin
        d8_run_q <= d8_run_q + 4'h1;
      end
    end
  end

  // a strobe under a settled divide-by-eight follows the last one by 8
  chk_div8_gap: assert property ( // RULE12
    (PCLK_EN_OUT && d8_run_q >= 4'h9) |-> gap_q == 4'h7)
    else $error("divide by eight strobe spacing wrong");

  chk_half_base: assert property ( // RULE14
    (CLK_DIV2_SEL_IN && !rot_en_q)[*3]
    |-> !(PCLK_EN_OUT && $past(PCLK_EN_OUT)))
    else $error("halved base clock ticks back to back");

  chk_stride_map: assert property ( // RULE15
    stride_q == 8'h00 |=> STRIDE_BYTES_OUT == 9'h100)
    else $error("zero stride not 256");

  chk_scratch_store: assert property ( // RULE7
    (wr_done && hit_scr) |=> scratch_q == $past(PWDATA_IN[7:0]))
    else $error("scratch write lost");

  cov_lut_commit: cover property (
    lut_acc && PWRITE_IN && comp_q == LAR_COMP_BLUE);
  cov_pin_readback: cover property (rd_done && hit_st && dir_q != 5'h00);
  cov_alt_mode: cover property (ROT_ALT_OUT && PCLK_EN_OUT);

endmodule : lar_top
`default_nettype wire

// >>> lar_top_tb.sv
`default_nettype none
`include "lar_defines.svh"

module lar_top_tb
  import lar_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int LIMIT = 10000;

  logic        clk        = 1'h0;
  logic        arst_n     = 1'h0;
  logic        psel       = 1'h0;
  logic        penable    = 1'h0;
  logic        pwrite     = 1'h0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ptr_load   = 1'h0;
  logic [7:0]  ptr_val    = 8'h00;
  logic [4:0]  gpio_in    = 5'h00;
  logic [4:0]  gpio_out;
  logic [4:0]  gpio_oe;
  logic        panel_mode = 1'h0;
  logic        div2_sel   = 1'h0;
  logic        mclk_cfg   = 1'h0;
  logic        rot_en;
  logic        rot_alt;
  logic        pclk_en;
  logic        mclk_en;
  logic [8:0]  stride;
  logic [31:0] rd;
  logic        err;
  logic [3:0]  nib [6];
  int          mismatches   = 0;
  int          total_checks = 0;
  int          cycles       = 0;

  always #20 clk = ~clk;

  lar_top u_lar_top (
    .CLK_IN             (clk),
    .ARST_N_IN          (arst_n),
    .PSEL_IN            (psel),
    .PENABLE_IN         (penable),
    .PWRITE_IN          (pwrite),
    .PADDR_IN           (paddr),
    .PWDATA_IN          (pwdata),
    .PRDATA_OUT         (prdata),
    .PREADY_OUT         (pready),
    .PSLVERR_OUT        (pslverr),
    .LUT_PTR_LOAD_IN    (ptr_load),
    .LUT_PTR_IN         (ptr_val),
    .GPIO_IN            (gpio_in),
    .GPIO_OUT           (gpio_out),
    .GPIO_OE_OUT        (gpio_oe),
    .PANEL_DATA_MODE_IN (panel_mode),
    .CLK_DIV2_SEL_IN    (div2_sel),
    .MCLK_CFG_IN        (mclk_cfg),
    .ROT_ENABLE_OUT     (rot_en),
    .ROT_ALT_OUT        (rot_alt),
    .PCLK_EN_OUT        (pclk_en),
    .MCLK_EN_OUT        (mclk_en),
    .STRIDE_BYTES_OUT   (stride)
  );

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what,
               got, exp);
    end
  endtask : chk

  // one apb transfer; answer is captured on the edge that sees pready
  task automatic apb(input logic wr, input logic [4:0] idx,
                     input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= {1'h0, idx, 2'h0};
    pwdata  <= {24'($urandom), wd};
    @(posedge clk);
    penable <= 1'h1;
    // ready is sampled on rising edges only; the bench timeout ends a hang
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1);
    rd  = prdata;
    err = pslverr;
    // one wait state: ready is seen on the second access edge
    chk(n, 32'h2, "access edges");
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic rdchk(input logic [4:0] idx, input logic [31:0] exp,
                       input string what);
    apb(1'h0, idx, 8'($urandom));
    chk(rd, exp, what);
  endtask : rdchk

  task automatic load_ptr(input logic [7:0] p);
    @(posedge clk);
    ptr_load <= 1'h1;
    ptr_val  <= p;
    @(posedge clk);
    ptr_load <= 1'h0;
  endtask : load_ptr

  function automatic int pdiv(logic en, logic alt, logic [1:0] sel,
                              logic d2);
    int d;
    d = !en ? 1 : (alt && sel == 2'h0) ? 2 : 1 << sel;
    return d << d2;
  endfunction : pdiv

  function automatic int mdiv(logic en, logic alt, logic [1:0] sel,
                              logic d2, logic cfg);
    int d;
    d = !en ? (cfg ? 2 : 1) : !alt ? 1 << sel :
        (sel == 2'h0) ? 1 : 1 << (sel - 1);
    return d << d2;
  endfunction : mdiv

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      $display("mismatch at %0t: run too long", $time);
      conclude();
    end
  end

  // factory test registers are never written by this bench
  initial begin
    logic [7:0] v;
    logic [4:0] dir;
    logic [4:0] st;
    logic [4:0] gin;
    logic       en;
    logic       alt;
    logic [1:0] sel;
    logic       d2;
    logic       cfg;
    int         pc;
    int         mc;
    void'($urandom(32'hC2767695));
    repeat (16) @(posedge clk);
    arst_n <= 1'h1;
    @(negedge clk);
    chk({23'h0, stride}, 32'h100, "stride at reset");
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'hFF : 8'($urandom);
      apb(1'h1, `LAR_IDX_SCRATCH, v);
      rdchk(`LAR_IDX_SCRATCH, {24'h0, v}, "scratch");
    end
    $display("scratch test done");
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : (i == 2) ? 8'hFF
          : 8'($urandom);
      apb(1'h1, `LAR_IDX_STRIDE, v);
      rdchk(`LAR_IDX_STRIDE, {24'h0, v}, "stride reg");
      @(negedge clk);
      chk({23'h0, stride}, (v == 8'h00) ? 32'h100 : {24'h0, v},
          "stride");
    end
    rdchk(5'h1D, 32'h0, "unmapped read");
    chk({31'h0, err}, 32'h1, "unmapped error");
    apb(1'h1, 5'h16, 8'hA5);
    chk({31'h0, err}, 32'h1, "unmapped write error");
    $display("stride and map test done");
    for (int i = 0; i < 5; i++) begin
      dir = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'($urandom);
      st  = 5'($urandom);
      gin = 5'($urandom);
      @(posedge clk);
      gpio_in <= gin;
      apb(1'h1, `LAR_IDX_PIN_DIR, {3'($urandom), dir});
      apb(1'h1, `LAR_IDX_PIN_STATE, {3'($urandom), st});
      repeat (4) @(negedge clk);
      chk({27'h0, gpio_oe}, {27'h0, dir}, "pin enable");
      chk({27'h0, gpio_out}, {27'h0, st & dir}, "pin drive");
      rdchk(`LAR_IDX_PIN_STATE, {27'h0, (st & dir) | (gin & ~dir)},
            "pin state");
      rdchk(`LAR_IDX_PIN_DIR, {27'h0, dir}, "pin dir");
      @(posedge clk);
      panel_mode <= 1'h1;
      repeat (4) @(negedge clk);
      chk({27'h0, gpio_oe}, 32'h0, "panel enable");
      @(posedge clk);
      panel_mode <= 1'h0;
    end
    $display("pin test done");
    // entries 255 and 0: pointer wraps after the blue of 255
    load_ptr(8'hFF);
    for (int i = 0; i < 6; i++) begin
      nib[i] = 4'($urandom);
      apb(1'h1, `LAR_IDX_LUT_DATA, {nib[i], 4'($urandom)});
    end
    // red and green staged without blue must not reach the table
    load_ptr(8'hFF);
    apb(1'h1, `LAR_IDX_LUT_DATA, {~nib[0], 4'hF});
    apb(1'h1, `LAR_IDX_LUT_DATA, {~nib[1], 4'hF});
    load_ptr(8'hFF);
    for (int i = 0; i < 6; i++) begin
      rdchk(`LAR_IDX_LUT_DATA, {24'h0, nib[i], 4'h0},
            "table");
    end
    $display("colour table test done");
    for (int i = 0; i < 32; i++) begin
      en  = i[4];
      alt = i[3];
      sel = i[2:1];
      d2  = i[0];
      cfg = 1'($urandom);
      @(posedge clk);
      div2_sel <= d2;
      mclk_cfg <= cfg;
      // reserved bit 2 kept zero, unused bits 5-3 random
      apb(1'h1, `LAR_IDX_ROT_MODE, {en, alt, 3'($urandom), 1'h0, sel});
      rdchk(`LAR_IDX_ROT_MODE, {24'h0, en, alt, 4'h0, sel},
            "rot mode");
      @(negedge clk);
      chk({30'h0, rot_en, rot_alt}, {30'h0, en, en & alt},
          "rot outputs");
      pc = 0;
      mc = 0;
      repeat (64) begin
        @(negedge clk);
        if (pclk_en === 1'h1) pc++;
        if (mclk_en === 1'h1) mc++;
      end
      chk(32'(pc), 32'(64 / pdiv(en, alt, sel, d2)),
          "pixel rate");
      chk(32'(mc), 32'(64 / mdiv(en, alt, sel, d2, cfg)),
          "memory rate");
    end
    $display("rotation clock test done");
    conclude();
  end

endmodule : lar_top_tb
`default_nettype wire
